//--- rtl/adc_fmt_pkg.sv
// Purpose : Constants for channel decode and result formatting of the queued converter
// Assumes : One clock, synchronous active-high reset
// Notes   : Result table is 64 words of 10 bits, three 16-bit views per word
package adc_fmt_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [23:0] RES_RIGHT_BASE  = 24'hCA0280;
   localparam logic [23:0] RES_LSIGN_BASE  = 24'hCA0300;
   localparam logic [23:0] RES_LUNS_BASE   = 24'hCA0380;
   localparam logic [23:0] CTRL_ZERO_ADDR  = 24'hCA000A;
   localparam int          CTRL_MUX_BIT    = 15;
   localparam int          ENTRY_COUNT     = 64;
   localparam int          RES_WIDTH       = 10;
   localparam logic [15:0] RESULT_RESET    = 16'h0000;
   localparam logic [15:0] READ_INVALID    = 16'h0000;

   // ---------------------------------------------------------------
   // Channel codes
   // ---------------------------------------------------------------
   localparam logic [5:0] CHANNEL_SELECT_MUX_ADDR0 = 6'h34;
   localparam logic [5:0] CHANNEL_SELECT_MUX_ADDR1 = 6'h35;
   localparam logic [5:0] CHANNEL_SELECT_TRIG1     = 6'h37;
   localparam logic [5:0] CHANNEL_SELECT_TRIG2     = 6'h38;
   localparam logic [5:0] CHANNEL_SELECT_REF_LOW   = 6'h3C;
   localparam logic [5:0] CHANNEL_SELECT_REF_HIGH  = 6'h3D;
   localparam logic [5:0] CHANNEL_SELECT_REF_MID   = 6'h3E;
   localparam logic [5:0] CHANNEL_SELECT_END_QUEUE = 6'h3F;

   typedef enum logic [3:0] {
      SRC_NONE  = 4'b0000,
      SRC_PIN0  = 4'b0001,
      SRC_PIN1  = 4'b0010,
      SRC_PIN2  = 4'b0011,
      SRC_PIN3  = 4'b0100,
      SRC_PIN52 = 4'b0101,
      SRC_PIN53 = 4'b0110,
      SRC_PIN55 = 4'b0111,
      SRC_PIN56 = 4'b1000,
      SRC_VRL   = 4'b1001,
      SRC_VRH   = 4'b1010,
      SRC_VMID  = 4'b1011
   } input_sel_t;

endpackage

//--- rtl/channel_select_if.sv
// Purpose : Carries a decoded channel between decoder and top
// Assumes : Driven combinationally by the decoder
// Notes   : None
`timescale 1ns/1ps
interface channel_select_if;
   import adc_fmt_pkg::*;
   logic [5:0]  channel_select;
   logic        mux_mode;
   input_sel_t  input_sel;
   logic [1:0]  mux_addr;
   logic        end_of_queue;
   logic        bypass_amp;
   logic        reserved;
   modport decoder (input channel_select, input mux_mode, output input_sel,
                    output mux_addr, output end_of_queue, output bypass_amp,
                    output reserved);
   modport user    (output channel_select, output mux_mode, input input_sel,
                    input mux_addr, input end_of_queue, input bypass_amp,
                    input reserved);
endinterface

//--- rtl/channel_select_decode.sv
// Purpose : Decode channel field into input select and mux address
// Assumes : Pure combinational
// Notes   : Reserved codes give SRC_NONE
`timescale 1ns/1ps
module channel_select_decode
   import adc_fmt_pkg::*;
(
   channel_select_if.decoder ch
);

   // ---------------------------------------------------------------
   // Multiplexed and direct form decode
   // ---------------------------------------------------------------
   wire [5:0] c         = ch.channel_select;
   wire       mux_group = (c[5:3] == 3'b000) || (c[5:3] == 3'b010);
   wire [1:0] mux_pin   = {c[4], c[0]};
   wire       direct_ok = (c[5:2] == 4'b0000);

   always_comb begin
      ch.input_sel    = SRC_NONE;
      ch.mux_addr     = c[2:1];
      ch.end_of_queue = (c == CHANNEL_SELECT_END_QUEUE);
      ch.bypass_amp   = (c == CHANNEL_SELECT_REF_LOW) || (c == CHANNEL_SELECT_REF_HIGH)
                        || (c == CHANNEL_SELECT_REF_MID);
      ch.reserved     = 1'b0;
      unique case (c)
         CHANNEL_SELECT_REF_LOW:   ch.input_sel = SRC_VRL;
         CHANNEL_SELECT_REF_HIGH:  ch.input_sel = SRC_VRH;
         CHANNEL_SELECT_REF_MID:   ch.input_sel = SRC_VMID;
         CHANNEL_SELECT_TRIG1:     ch.input_sel = SRC_PIN55;
         CHANNEL_SELECT_TRIG2:     ch.input_sel = SRC_PIN56;
         CHANNEL_SELECT_MUX_ADDR0: ch.input_sel = ch.mux_mode ? SRC_NONE : SRC_PIN52;
         CHANNEL_SELECT_MUX_ADDR1: ch.input_sel = ch.mux_mode ? SRC_NONE : SRC_PIN53;
         CHANNEL_SELECT_END_QUEUE: ch.input_sel = SRC_NONE;
         default: begin
            if (ch.mux_mode && mux_group) begin
               ch.input_sel = input_sel_t'({2'b00, mux_pin} + 4'b0001);
            end else if (!ch.mux_mode && direct_ok) begin
               ch.input_sel = input_sel_t'({2'b00, c[1:0]} + 4'b0001);
            end else begin
               ch.reserved = 1'b1;
            end
         end
      endcase
      if (ch.mux_mode && (c == CHANNEL_SELECT_MUX_ADDR0 || c == CHANNEL_SELECT_MUX_ADDR1)) begin
         ch.reserved = 1'b1;
      end
   end

endmodule // channel_select_decode

//--- rtl/adc_result_format_ext_mux_decode.sv
// Purpose : Result table with three read views and external mux addressing
// Assumes : Synchronous bus, one-cycle read data, stop mode freezes the table and clears mux mode
// Notes   : Views alias one 10-bit stored word per entry
`timescale 1ns/1ps
module adc_result_format_ext_mux_decode
   import adc_fmt_pkg::*;
#(
   parameter int ENTRIES = ENTRY_COUNT
)(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        stop_mode,
   // Register bus
   input  wire logic        bus_sel,
   input  wire logic        bus_write,
   input  wire logic [23:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   output logic      [15:0] bus_rdata,
   output logic             bus_ack,
   output logic             bus_err,
   // Command word being executed
   input  wire logic        cmd_valid,
   input  wire logic [5:0]  channel_select,
   // Conversion result write path
   input  wire logic        conv_done,
   input  wire logic [5:0]  conv_index,
   input  wire logic [9:0]  conv_result,
   // Decoded outputs
   output logic      [3:0]  input_select,
   output logic             end_of_queue,
   output logic             bypass_amp,
   output logic             channel_reserved,
   output logic      [1:0]  mux_address_out,
   output logic      [1:0]  mux_address_oe,
   output logic             mux_mode
);

   // ---------------------------------------------------------------
   // Control register zero (mux-select bit)
   // ---------------------------------------------------------------
   logic mux_mode_q;
   logic mux_mode_d;
   wire  active     = clk_en && !stop_mode;
   wire  ctrl_hit   = bus_sel && (bus_addr == CTRL_ZERO_ADDR);
   wire  ctrl_wr    = ctrl_hit && bus_write;

   assign mux_mode_d = ctrl_wr ? bus_wdata[CTRL_MUX_BIT] : mux_mode_q;

   always_ff @(posedge clock) begin
      if (rst || (clk_en && stop_mode)) begin
         mux_mode_q <= 1'b0;
      end else if (active) begin
         mux_mode_q <= mux_mode_d;
      end
   end

   // ---------------------------------------------------------------
   // Channel decode
   // ---------------------------------------------------------------
   channel_select_if ch ();
   assign ch.channel_select = channel_select;
   assign ch.mux_mode       = mux_mode_q;

   channel_select_decode u_decode (
      .ch (ch)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         input_select     <= 4'h0;
         end_of_queue     <= 1'b0;
         bypass_amp       <= 1'b0;
         channel_reserved <= 1'b0;
         mux_address_out  <= 2'h0;
         mux_address_oe   <= 2'h0;
         mux_mode         <= 1'b0;
      end else if (clk_en) begin
         mux_mode       <= mux_mode_q;
         mux_address_oe <= {2{mux_mode_q}};
         if (cmd_valid && mux_mode_q) begin
            mux_address_out <= ch.mux_addr;
         end
         if (cmd_valid) begin
            input_select     <= ch.input_sel;
            end_of_queue     <= ch.end_of_queue;
            bypass_amp       <= ch.bypass_amp;
            channel_reserved <= ch.reserved;
         end
      end
   end

   // ---------------------------------------------------------------
   // Result storage, one word per entry
   // ---------------------------------------------------------------
   logic [RES_WIDTH-1:0] result_q [ENTRIES];

   wire [23:0] off_right = bus_addr - RES_RIGHT_BASE;
   wire [23:0] off_lsign = bus_addr - RES_LSIGN_BASE;
   wire [23:0] off_luns  = bus_addr - RES_LUNS_BASE;
   wire        hit_right = (bus_addr >= RES_RIGHT_BASE) && (off_right < 24'h80);
   wire        hit_lsign = (bus_addr >= RES_LSIGN_BASE) && (off_lsign < 24'h80);
   wire        hit_luns  = (bus_addr >= RES_LUNS_BASE) && (off_luns < 24'h80);
   wire        res_hit   = hit_right || hit_lsign || hit_luns;
   wire [5:0]  bus_index = hit_right ? off_right[6:1] :
                           hit_lsign ? off_lsign[6:1] : off_luns[6:1];

   // Only the result field of each view is writable; zero bits are dropped
   wire [9:0]  wr_value  = hit_right ? bus_wdata[9:0] :
                           hit_lsign ? {~bus_wdata[15], bus_wdata[14:6]} :
                                       bus_wdata[15:6];
   wire        bus_res_wr = bus_sel && bus_write && res_hit && active;

   genvar gi;
   generate
      for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
         always_ff @(posedge clock) begin
            if (rst) begin
               result_q[gi] <= RESULT_RESET[RES_WIDTH-1:0];
            end else if (active) begin
               // Converter write wins over a same-cycle bus write
               if (conv_done && conv_index == 6'(gi)) begin
                  result_q[gi] <= conv_result;
               end else if (bus_res_wr && bus_index == 6'(gi)) begin
                  result_q[gi] <= wr_value;
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Read views
   // ---------------------------------------------------------------
   wire [9:0]  rd_word   = result_q[bus_index];
   wire [15:0] view_r    = {6'h00, rd_word};
   wire [15:0] view_s    = {~rd_word[9], rd_word[8:0], 6'h00};
   wire [15:0] view_u    = {rd_word, 6'h00};
   wire [15:0] ctrl_view = {mux_mode_q, 15'h0000};
   // Each half-word is independent; no latch spans two reads
   wire [15:0] rd_mux    = stop_mode ? READ_INVALID :
                           hit_right ? view_r :
                           hit_lsign ? view_s :
                           hit_luns  ? view_u :
                           ctrl_hit  ? ctrl_view : 16'h0000;

   always_ff @(posedge clock) begin
      if (rst) begin
         bus_rdata <= 16'h0000;
         bus_ack   <= 1'b0;
         bus_err   <= 1'b0;
      end else if (clk_en) begin
         bus_ack   <= bus_sel;
         bus_err   <= 1'b0;
         bus_rdata <= (bus_sel && !bus_write) ? rd_mux : 16'h0000;
      end
   end

endmodule // adc_result_format_ext_mux_decode

//--- bench/adc_fmt_properties.sv
// Purpose : Concurrent checks on the result views and channel decode outputs
// Assumes : Sees only the top module ports, one clock domain
// Notes   : Bound to the top module below
`timescale 1ns/1ps
module adc_fmt_properties
   import adc_fmt_pkg::*;
#(
   parameter int ENTRIES = ENTRY_COUNT
)(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        stop_mode,
   input wire logic        bus_sel,
   input wire logic        bus_write,
   input wire logic [23:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic        bus_ack,
   input wire logic        bus_err,
   input wire logic        cmd_valid,
   input wire logic [5:0]  channel_select,
   input wire logic        conv_done,
   input wire logic [5:0]  conv_index,
   input wire logic [9:0]  conv_result,
   input wire logic [3:0]  input_select,
   input wire logic        end_of_queue,
   input wire logic        bypass_amp,
   input wire logic        channel_reserved,
   input wire logic [1:0]  mux_address_out,
   input wire logic [1:0]  mux_address_oe,
   input wire logic        mux_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_rd;
      bus_sel && !bus_write && clk_en && !stop_mode;
   endsequence
   sequence s_cmd;
      cmd_valid && clk_en;
   endsequence
   AST_ACK: assert property (bus_sel && clk_en |=> bus_ack && !bus_err)
      else $error("bus access not acked cleanly");
   AST_STOP_RD: assert property (bus_sel && !bus_write && stop_mode && clk_en |=>
      bus_rdata == READ_INVALID) else $error("stop read not invalid");
   AST_RIGHT: assert property (s_rd ##0 bus_addr[23:7] == RES_RIGHT_BASE[23:7] |=>
      bus_rdata[15:10] == 6'h00) else $error("right view upper bits set");
   AST_LEFT: assert property (s_rd ##0 bus_addr[23:8] == RES_LSIGN_BASE[23:8] |=>
      bus_rdata[5:0] == 6'h00) else $error("left view low bits set");
   AST_OE: assert property (mux_mode [*2] |-> mux_address_oe == 2'b11)
      else $error("address pins not driven");
   // The mode output is a registered copy of the control bit, so it clears one edge later
   AST_STOP_MUX: assert property (stop_mode && clk_en |-> ##2 !mux_mode)
      else $error("mux mode kept in stop");
   AST_MUX_ADDR: assert property (s_cmd ##0 (mux_mode && !channel_select[5] &&
      !channel_select[3]) |=> mux_address_out == $past(channel_select[2:1]))
      else $error("mux address wrong");
   AST_EOQ: assert property (s_cmd ##0 channel_select == CHANNEL_SELECT_END_QUEUE |=> end_of_queue)
      else $error("end of queue missed");
   AST_REF: assert property (s_cmd ##0 channel_select inside {[CHANNEL_SELECT_REF_LOW:CHANNEL_SELECT_REF_MID]}
      |=> bypass_amp) else $error("reference channel not bypassed");
endmodule // adc_fmt_properties

bind adc_result_format_ext_mux_decode adc_fmt_properties #(.ENTRIES(ENTRIES)) i_props (
   .clock(clock), .rst(rst), .clk_en(clk_en), .stop_mode(stop_mode), .bus_sel(bus_sel),
   .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .bus_ack(bus_ack), .bus_err(bus_err), .cmd_valid(cmd_valid),
   .channel_select(channel_select), .conv_done(conv_done), .conv_index(conv_index),
   .conv_result(conv_result), .input_select(input_select), .end_of_queue(end_of_queue),
   .bypass_amp(bypass_amp), .channel_reserved(channel_reserved),
   .mux_address_out(mux_address_out), .mux_address_oe(mux_address_oe), .mux_mode(mux_mode));

//--- bench/ext_mux_model.sv
// Purpose : Four external 4-input mux chips sharing two address lines
// Assumes : Lines not driven by the block float, shown as the inverse
// Notes   : Gives the input index every chip has picked
`timescale 1ns/1ps
module ext_mux_model (
   input  wire logic [1:0] mux_address_out,
   input  wire logic [1:0] mux_address_oe,
   output logic      [1:0] picked
);
   // Undriven lines must not look like a valid address
   assign picked = (mux_address_oe == 2'b11) ? mux_address_out : ~mux_address_out;
endmodule // ext_mux_model

//--- bench/tb_top.sv
// Purpose : Self-checking bench for result views and channel decode
// Assumes : clk_en held high, inputs driven on the rising edge
// Notes   : Expected values worked out from the result layouts
`timescale 1ns/1ps
module tb_top;
   import adc_fmt_pkg::*;
   logic        clock, rst, clk_en, stop_mode, bus_sel, bus_write, cmd_valid, conv_done;
   logic [23:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, rd;
   logic        bus_ack, bus_err, end_of_queue, bypass_amp, channel_reserved, mux_mode;
   logic [5:0]  channel_select, conv_index, ch;
   logic [9:0]  conv_result;
   logic [3:0]  input_select;
   logic [1:0]  mux_address_out, mux_address_oe, picked;
   int          errors, checks_done;

   adc_result_format_ext_mux_decode #(.ENTRIES(64)) i_dut (.clock(clock), .rst(rst),
      .clk_en(clk_en), .stop_mode(stop_mode), .bus_sel(bus_sel), .bus_write(bus_write),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .bus_err(bus_err), .cmd_valid(cmd_valid), .channel_select(channel_select),
      .conv_done(conv_done), .conv_index(conv_index), .conv_result(conv_result),
      .input_select(input_select), .end_of_queue(end_of_queue), .bypass_amp(bypass_amp),
      .channel_reserved(channel_reserved), .mux_address_out(mux_address_out),
      .mux_address_oe(mux_address_oe), .mux_mode(mux_mode));
   ext_mux_model i_mux (.mux_address_out(mux_address_out), .mux_address_oe(mux_address_oe),
      .picked(picked));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task print_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task check_val(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [23:0] a, input logic [15:0] d);
      @(posedge clock);
      bus_sel <= 1'b1; bus_write <= w; bus_addr <= a; bus_wdata <= d;
      @(posedge clock);
      bus_sel <= 1'b0;
      #1 rd = bus_rdata;
      check_val({15'h0000, bus_ack}, 16'h0001);
      check_val({15'h0000, bus_err}, 16'h0000);
   endtask
   task rd_chk(input logic [23:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0000);
      check_val(rd, exp);
   endtask
   task cmd(input logic [5:0] c);
      @(posedge clock);
      cmd_valid <= 1'b1; channel_select <= c;
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (3000) @(posedge clock);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      print_verdict;
   end
   initial begin
      rst = 1'b1; clk_en = 1'b1; stop_mode = 1'b0; bus_sel = 1'b0; bus_write = 1'b0;
      bus_addr = 24'h000000; bus_wdata = 16'h0000; cmd_valid = 1'b0; channel_select = 6'h00;
      conv_done = 1'b0; conv_index = 6'h00; conv_result = 10'h000; errors = 0; checks_done = 0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd_chk(RES_RIGHT_BASE, RESULT_RESET);
      check_val({15'h0000, mux_mode}, 16'h0000);
      check_val({14'h0000, mux_address_oe}, 16'h0000);
      @(posedge clock);
      conv_done <= 1'b1; conv_index <= 6'h05; conv_result <= 10'h2A5;
      @(posedge clock);
      conv_done <= 1'b0;
      rd_chk(RES_RIGHT_BASE + 24'h00000A, 16'h02A5);
      rd_chk(RES_LUNS_BASE + 24'h00000A, 16'hA940);
      rd_chk(RES_LSIGN_BASE + 24'h00000A, 16'h2940);
      bus(1'b1, RES_RIGHT_BASE + 24'h00000A, 16'hFFFF);
      rd_chk(RES_RIGHT_BASE + 24'h00000A, 16'h03FF);
      bus(1'b1, RES_LSIGN_BASE + 24'h00000C, 16'h0000);
      rd_chk(RES_RIGHT_BASE + 24'h00000C, 16'h0200);
      $display("test result views done");
      bus(1'b1, CTRL_ZERO_ADDR, 16'h8000);
      // Mode bit and enables each lag one cycle
      repeat (2) @(posedge clock);
      #1 check_val({14'h0000, mux_address_oe}, 16'h0003);
      for (int i = 0; i < 16; i++) begin
         ch = {1'b0, i[3], 1'b0, i[2:0]};
         cmd(ch);
         check_val({14'h0000, picked}, {14'h0000, ch[2:1]});
         check_val({12'h000, input_select}, 16'(SRC_PIN0 + {ch[4], ch[0]}));
      end
      cmd(6'h08);
      check_val({15'h0000, channel_reserved}, 16'h0001);
      // Address pin codes are outputs in mux mode, not conversion inputs
      cmd(CHANNEL_SELECT_MUX_ADDR0);
      check_val({15'h0000, channel_reserved}, 16'h0001);
      check_val({12'h000, input_select}, 16'(SRC_NONE));
      cmd(CHANNEL_SELECT_END_QUEUE);
      check_val({15'h0000, end_of_queue}, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         cmd(CHANNEL_SELECT_REF_LOW + 6'(i));
         check_val({15'h0000, bypass_amp}, 16'h0001);
         check_val({12'h000, input_select}, 16'(SRC_VRL + i));
      end
      $display("test channel decode done");
      @(posedge clock);
      stop_mode <= 1'b1;
      bus(1'b1, RES_RIGHT_BASE + 24'h00000A, 16'h0001);
      rd_chk(RES_RIGHT_BASE + 24'h00000A, READ_INVALID);
      check_val({15'h0000, mux_mode}, 16'h0000);
      @(posedge clock);
      stop_mode <= 1'b0;
      rd_chk(RES_RIGHT_BASE + 24'h00000A, 16'h03FF);
      bus(1'b1, RES_RIGHT_BASE + 24'h00000A, 16'h0155);
      rd_chk(RES_RIGHT_BASE + 24'h00000A, 16'h0155);
      // Stop cleared mux mode, so the direct assignment applies again
      check_val({14'h0000, mux_address_oe}, 16'h0000);
      cmd(6'h02);
      check_val({12'h000, input_select}, 16'(SRC_PIN2));
      check_val({15'h0000, channel_reserved}, 16'h0000);
      cmd(CHANNEL_SELECT_MUX_ADDR0);
      check_val({12'h000, input_select}, 16'(SRC_PIN52));
      cmd(CHANNEL_SELECT_TRIG1);
      check_val({12'h000, input_select}, 16'(SRC_PIN55));
      cmd(6'h05);
      check_val({15'h0000, channel_reserved}, 16'h0001);
      $display("test stop mode done");
      print_verdict;
   end
endmodule // tb_top
